// ### src/ssc_defs.vh
// register map, field positions, reset values and timing counts of the standby controller
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH
`define SSC_ADDR_W 4
`define SSC_OFS_STANDBY 4'h0
`define SSC_OFS_MSTOP_A 4'h1
`define SSC_OFS_MSTOP_B 4'h2
`define SSC_OFS_MSTOP_C 4'h3
`define SSC_OFS_OPC 4'h4
`define SSC_OFS_OSCWAIT 4'h5
`define SSC_OFS_SWRESET 4'h6
`define SSC_OFS_PROTECT 4'h7
`define SSC_OFS_WDTCFG 4'h8
`define SSC_OFS_STATUS 4'h9
`define SSC_OFS_OSCEN 4'ha
`define SSC_BIT_STANDBY_SELECT_BIT 15
`define SSC_BIT_PROTECT_LOWPOWER_ENABLE 1
`define SSC_PRC_MASK 8'h0b
`define SSC_PROTECT_KEY 8'ha5
`define SSC_SWRESET_KEY 16'ha501
`define SSC_MSTOP_A_RST 32'hffff_ffff
`define SSC_MSTOP_B_RST 32'hffff_ffff
`define SSC_MSTOP_C_RST 32'hffff_0000
`define SSC_OSCWAIT_RST 5'h04
`define SSC_OSCEN_RST 3'h1
`define SSC_BIT_DTC_STOP 28
`define SSC_WAIT_UNIT_TICKS 16'h0010
`define SSC_PRESCALE 4'h9
`endif

// ### src/ssc_osc_wait.v
// oscillator stabilisation wait counter run from a free running tick
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.vh"
module ssc_osc_wait
(
  input wire clk_sys,
  input wire rst_n,
  input wire start,
  input wire tick,
  input wire [4:0] wait_units,
  output reg busy,
  output reg done
);
  reg [20:0] count;

  // load on start, count down on each tick, pulse done at terminal count
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 21'h000000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count <= {16'h0000, wait_units} * {5'h00, `SSC_WAIT_UNIT_TICKS} + 21'h000001;
        busy <= 1'b1;
      end
      else if (busy && tick)
      begin
        if (count == 21'h000001)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count - 21'h000001;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/ssc_standby_ctrl.v
// software standby controller: entry, wake, watchdog stop, module stop and write protect
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.vh"
module ssc_standby_ctrl
(
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire halt_exec,
  input wire write_pending,
  input wire nmi_pin,
  input wire [5:0] external_irq_lines,
  input wire watchdog_irq,
  input wire monitor_irq,
  input wire reset_pin_n,
  input wire power_on_reset,
  input wire monitor_reset,
  input wire watchdog_underflow,
  input wire watchdog_start_mode_option,
  input wire autostart_sleep_stop_option,
  output reg cpu_clock_en,
  output reg periph_clock_en,
  output reg [2:0] osc_enable,
  output reg set_interrupt_enable_flag,
  output reg wake_irq_start,
  output reg reset_hold,
  output reg watchdog_count_en,
  output reg in_standby,
  output reg [31:0] module_stop_a,
  output reg [31:0] module_stop_b,
  output reg [31:0] module_stop_c,
  output reg [2:0] operating_power_mode,
  output reg software_reset
);
  localparam ST_RUN = 3'd0;
  localparam ST_STANDBY = 3'd1;
  localparam ST_WAKE_IRQ = 3'd2;
  localparam ST_WAKE_PIN = 3'd3;
  localparam ST_RESET_HOLD = 3'd4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] standby_control_reg;
  reg [4:0] osc_wait_time_field;
  reg [7:0] write_protect_reg;
  reg regstart_sleep_stop_bit;
  reg [2:0] osc_run_set;
  reg [2:0] osc_saved;
  reg [3:0] prescale;
  reg tick;
  reg [2:0] sync_nmi;
  reg [2:0] sync_rst;
  reg [2:0] sync_por;
  reg [2:0] sync_mon;
  reg [17:0] sync_irq;
  reg nmi_s;
  reg rst_pin_low;
  reg por_s;
  reg mon_s;
  reg [5:0] irq_s;
  reg wait_start;
  wire wait_busy;
  wire wait_done;
  wire protect_open;
  wire be_all;
  wire wdt_stopped;
  wire irq_wake;
  wire hard_reset;
  wire bus_write;
  reg [31:0] next_readdata;

  // three stage filter: a change counts once stages two and three agree
  function filt;
    input [2:0] s;
    input old;
    begin
      filt = (s[1] == s[2]) ? s[2] : old;
    end
  endfunction

  ssc_osc_wait u_wait
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(wait_start),
    .tick(tick),
    .wait_units(osc_wait_time_field),
    .busy(wait_busy),
    .done(wait_done)
  );

  assign protect_open = write_protect_reg[`SSC_BIT_PROTECT_LOWPOWER_ENABLE];
  assign be_all = (avs_byteenable == 4'hf);
  assign bus_write = avs_write && !avs_waitrequest;
  // stopped when the active start mode's stop setting is one
  assign wdt_stopped = watchdog_start_mode_option ? regstart_sleep_stop_bit
                                                  : autostart_sleep_stop_option;
  assign irq_wake = nmi_s || (|irq_s) || watchdog_irq || monitor_irq;
  assign hard_reset = por_s || mon_s || (watchdog_underflow && !(in_standby && wdt_stopped));

  // pin synchronisers and free running tick for the wait counter
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_nmi <= 3'h0;
      sync_rst <= 3'h7;
      sync_por <= 3'h0;
      sync_mon <= 3'h0;
      sync_irq <= 18'h00000;
      nmi_s <= 1'b0;
      rst_pin_low <= 1'b0;
      por_s <= 1'b0;
      mon_s <= 1'b0;
      irq_s <= 6'h00;
      prescale <= 4'h0;
      tick <= 1'b0;
    end
    else
    begin
      sync_nmi <= {sync_nmi[1:0], nmi_pin};
      sync_rst <= {sync_rst[1:0], reset_pin_n};
      sync_por <= {sync_por[1:0], power_on_reset};
      sync_mon <= {sync_mon[1:0], monitor_reset};
      sync_irq <= {sync_irq[11:0], external_irq_lines};
      nmi_s <= filt(sync_nmi, nmi_s);
      rst_pin_low <= !filt(sync_rst, !rst_pin_low);
      por_s <= filt(sync_por, por_s);
      mon_s <= filt(sync_mon, mon_s);
      irq_s <= (sync_irq[11:6] ~^ sync_irq[17:12]) & sync_irq[17:12]
               | ~(sync_irq[11:6] ~^ sync_irq[17:12]) & irq_s;
      tick <= (prescale == `SSC_PRESCALE);
      prescale <= (prescale == `SSC_PRESCALE) ? 4'h0 : prescale + 4'h1; // keeps running in standby
    end
  end

  // standby sequencer next state
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (rst_pin_low)
          next_state = ST_WAKE_PIN;
        else if (hard_reset)
          next_state = ST_RESET_HOLD;
        else if (halt_exec && !write_pending && standby_control_reg[`SSC_BIT_STANDBY_SELECT_BIT])
          next_state = ST_STANDBY;
      ST_STANDBY:
        if (rst_pin_low)
          next_state = ST_WAKE_PIN;
        else if (hard_reset)
          next_state = ST_RESET_HOLD;
        else if (irq_wake)
          next_state = ST_WAKE_IRQ;
      ST_WAKE_IRQ:
        if (rst_pin_low)
          next_state = ST_WAKE_PIN;
        else if (hard_reset)
          next_state = ST_RESET_HOLD;
        else if (wait_done)
          next_state = ST_RUN;
      ST_WAKE_PIN:
        if (!rst_pin_low)
          next_state = ST_RESET_HOLD;
      ST_RESET_HOLD:
        if (rst_pin_low)
          next_state = ST_WAKE_PIN;
        else if (!hard_reset)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // sequencer state and clock, watchdog and wake outputs
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_RUN;
      osc_saved <= `SSC_OSCEN_RST;
      cpu_clock_en <= 1'b1;
      periph_clock_en <= 1'b1;
      osc_enable <= `SSC_OSCEN_RST;
      set_interrupt_enable_flag <= 1'b0;
      wake_irq_start <= 1'b0;
      reset_hold <= 1'b0;
      watchdog_count_en <= 1'b1;
      in_standby <= 1'b0;
      wait_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      set_interrupt_enable_flag <= 1'b0;
      wake_irq_start <= 1'b0;
      wait_start <= 1'b0;
      // halt sets the enable flag whatever mode follows
      if (state == ST_RUN && halt_exec && !write_pending)
        set_interrupt_enable_flag <= 1'b1;
      if (state == ST_RUN && next_state == ST_STANDBY)
      begin
        osc_saved <= osc_run_set; // remember running oscillators
        osc_enable <= 3'h0;
        cpu_clock_en <= 1'b0;
        periph_clock_en <= 1'b0;
        in_standby <= 1'b1;
        watchdog_count_en <= !wdt_stopped;
      end
      if (state == ST_STANDBY && next_state == ST_WAKE_IRQ)
      begin
        osc_enable <= osc_saved;
        wait_start <= 1'b1;
      end
      if (next_state == ST_WAKE_PIN || next_state == ST_RESET_HOLD)
      begin
        osc_enable <= in_standby ? osc_saved : osc_run_set;
        cpu_clock_en <= 1'b1;
        periph_clock_en <= 1'b1;
        in_standby <= 1'b0;
        watchdog_count_en <= 1'b1;
        reset_hold <= 1'b1;
      end
      if (state == ST_WAKE_IRQ && next_state == ST_RUN)
      begin
        cpu_clock_en <= 1'b1;
        periph_clock_en <= 1'b1;
        in_standby <= 1'b0;
        watchdog_count_en <= 1'b1;
        wake_irq_start <= 1'b1;
      end
      if (state == ST_RESET_HOLD && next_state == ST_RUN)
        reset_hold <= 1'b0;
    end
  end

  // register writes: protected group needs the low power protect bit
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      standby_control_reg <= 16'h0000;
      module_stop_a <= `SSC_MSTOP_A_RST;
      module_stop_b <= `SSC_MSTOP_B_RST;
      module_stop_c <= `SSC_MSTOP_C_RST;
      operating_power_mode <= 3'h0;
      osc_wait_time_field <= `SSC_OSCWAIT_RST;
      write_protect_reg <= 8'h00;
      regstart_sleep_stop_bit <= 1'b0;
      osc_run_set <= `SSC_OSCEN_RST;
      software_reset <= 1'b0;
    end
    else
    begin
      software_reset <= 1'b0;
      if (bus_write && be_all && protect_open)
      begin
        case (avs_address)
          `SSC_OFS_STANDBY: standby_control_reg <= avs_writedata[15:0] & 16'h8000;
          `SSC_OFS_MSTOP_A: module_stop_a <= avs_writedata;
          `SSC_OFS_MSTOP_B: module_stop_b <= avs_writedata; // stopped modules keep interrupts idle
          `SSC_OFS_MSTOP_C: module_stop_c <= avs_writedata;
          `SSC_OFS_OPC: operating_power_mode <= avs_writedata[2:0];
          `SSC_OFS_OSCWAIT: osc_wait_time_field <= avs_writedata[4:0];
          `SSC_OFS_OSCEN: osc_run_set <= avs_writedata[2:0];
          `SSC_OFS_SWRESET: software_reset <= (avs_writedata[15:0] == `SSC_SWRESET_KEY);
          default: software_reset <= 1'b0;
        endcase
      end
      // key must accompany a sixteen bit write
      if (bus_write && avs_address == `SSC_OFS_PROTECT && avs_byteenable[1:0] == 2'h3
          && avs_writedata[15:8] == `SSC_PROTECT_KEY)
        write_protect_reg <= avs_writedata[7:0] & `SSC_PRC_MASK;
      if (bus_write && avs_address == `SSC_OFS_WDTCFG && avs_byteenable[0])
        regstart_sleep_stop_bit <= avs_writedata[0];
    end
  end

  // read mux, status word shows sequencer state
  always @*
  begin
    case (avs_address)
      `SSC_OFS_STANDBY: next_readdata = {16'h0000, standby_control_reg};
      `SSC_OFS_MSTOP_A: next_readdata = module_stop_a;
      `SSC_OFS_MSTOP_B: next_readdata = module_stop_b;
      `SSC_OFS_MSTOP_C: next_readdata = module_stop_c;
      `SSC_OFS_OPC: next_readdata = {29'h0, operating_power_mode};
      `SSC_OFS_OSCWAIT: next_readdata = {27'h0, osc_wait_time_field};
      `SSC_OFS_PROTECT: next_readdata = {24'h0, write_protect_reg};
      `SSC_OFS_WDTCFG: next_readdata = {31'h0, regstart_sleep_stop_bit};
      `SSC_OFS_STATUS: next_readdata = {24'h0, wait_busy, wdt_stopped, rst_pin_low, in_standby, 1'b0, state};
      `SSC_OFS_OSCEN: next_readdata = {29'h0, osc_run_set};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // avalon slave: one wait cycle, answer at the second edge
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      if ((avs_read || avs_write) && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
      end
      else
        avs_waitrequest <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb/ssc_checker_assertions.sv
// port level assertions of the standby controller
`timescale 1ns/1ns
`default_nettype none
module ssc_checker
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic halt_exec,
  input wire logic write_pending,
  input wire logic reset_pin_n,
  input wire logic power_on_reset,
  input wire logic watchdog_start_mode_option,
  input wire logic autostart_sleep_stop_option,
  input wire logic cpu_clock_en,
  input wire logic periph_clock_en,
  input wire logic [2:0] osc_enable,
  input wire logic set_interrupt_enable_flag,
  input wire logic wake_irq_start,
  input wire logic reset_hold,
  input wire logic watchdog_count_en,
  input wire logic in_standby
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_pin_low; !reset_pin_n [*6]; endsequence
  sequence s_por; power_on_reset [*6]; endsequence
  sequence s_entry; $rose(in_standby); endsequence
  property p_entry; s_entry |-> $past(halt_exec && !write_pending); endproperty
  a_entry: assert property (p_entry) else $error("standby entered without accepted halt");
  property p_ief; s_entry |-> set_interrupt_enable_flag; endproperty
  a_ief: assert property (p_ief) else $error("interrupt enable not set on halt");
  property p_stop; s_entry |-> !cpu_clock_en && !periph_clock_en && osc_enable == 3'h0; endproperty
  a_stop: assert property (p_stop) else $error("clocks not stopped in standby");
  property p_wdt_stop; s_entry ##0 (!watchdog_start_mode_option && autostart_sleep_stop_option) |-> !watchdog_count_en; endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog still counting");
  property p_wdt_run; s_entry ##0 (!watchdog_start_mode_option && !autostart_sleep_stop_option) |-> watchdog_count_en; endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog stopped");
  property p_wake_clk; wake_irq_start |-> cpu_clock_en && periph_clock_en; endproperty
  a_wake_clk: assert property (p_wake_clk) else $error("wake without clocks");
  property p_wake_osc; wake_irq_start |-> $past(osc_enable, 2) != 3'h0; endproperty
  a_wake_osc: assert property (p_wake_osc) else $error("wake before oscillator wait");
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus access not answered");
  property p_pin; s_pin_low |-> reset_hold && cpu_clock_en; endproperty
  a_pin: assert property (p_pin) else $error("reset pin low without reset hold");
  property p_por; s_por |-> reset_hold; endproperty
  a_por: assert property (p_por) else $error("power on reset not held");
endmodule
bind ssc_standby_ctrl ssc_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .halt_exec(halt_exec), .write_pending(write_pending),
  .reset_pin_n(reset_pin_n), .power_on_reset(power_on_reset), .watchdog_start_mode_option(watchdog_start_mode_option),
  .autostart_sleep_stop_option(autostart_sleep_stop_option), .cpu_clock_en(cpu_clock_en),
  .periph_clock_en(periph_clock_en), .osc_enable(osc_enable), .set_interrupt_enable_flag(set_interrupt_enable_flag),
  .wake_irq_start(wake_irq_start), .reset_hold(reset_hold), .watchdog_count_en(watchdog_count_en),
  .in_standby(in_standby));
`default_nettype wire

// ### tb/ssc_wake_src.sv
// far side model: wake and reset pins facing the standby controller
`timescale 1ns/1ns
`default_nettype none
module ssc_wake_src
(
  output logic nmi_pin,
  output logic [5:0] external_irq_lines,
  output logic watchdog_irq,
  output logic monitor_irq,
  output logic reset_pin_n,
  output logic power_on_reset,
  output logic monitor_reset,
  output logic watchdog_underflow
);
  logic [12:0] v = 13'h0000;
  // each request bit drives one wake or reset source; the reset pin is active low
  assign nmi_pin = v[0];
  assign external_irq_lines = v[6:1];
  assign watchdog_irq = v[7];
  assign monitor_irq = v[8];
  assign reset_pin_n = ~v[9];
  assign power_on_reset = v[10];
  assign watchdog_underflow = v[11];
  assign monitor_reset = v[12];
  // raise one source just after a clock edge
  task raise(input int k);
    v[k] <= 1'b1;
  endtask
  // release every source
  task drop();
    v <= 13'h0000;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench of the standby controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic halt_exec = 1'b0;
  logic write_pending = 1'b0;
  logic wd_opt = 1'b1;
  logic wd_mode = 1'b0;
  logic [31:0] avs_readdata, ma, mb, mc, rv;
  logic avs_waitrequest, cpu_clock_en, periph_clock_en, ief, wake_irq_start, reset_hold, wdt_en, in_standby, swr;
  logic [2:0] osc_enable, opm;
  logic nmi_pin, wdt_irq, mon_irq, reset_pin_n, por, mon_rst, wdt_uf;
  logic [5:0] ext_irq;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  // system clock
  initial forever #5 clk_sys = ~clk_sys;
  ssc_wake_src wk (.nmi_pin(nmi_pin), .external_irq_lines(ext_irq), .watchdog_irq(wdt_irq), .monitor_irq(mon_irq),
    .reset_pin_n(reset_pin_n), .power_on_reset(por), .monitor_reset(mon_rst), .watchdog_underflow(wdt_uf));
  ssc_standby_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_exec(halt_exec),
    .write_pending(write_pending), .nmi_pin(nmi_pin), .external_irq_lines(ext_irq), .watchdog_irq(wdt_irq),
    .monitor_irq(mon_irq), .reset_pin_n(reset_pin_n), .power_on_reset(por), .monitor_reset(mon_rst),
    .watchdog_underflow(wdt_uf), .watchdog_start_mode_option(wd_mode), .autostart_sleep_stop_option(wd_opt),
    .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en), .osc_enable(osc_enable),
    .set_interrupt_enable_flag(ief), .wake_irq_start(wake_irq_start), .reset_hold(reset_hold),
    .watchdog_count_en(wdt_en), .in_standby(in_standby), .module_stop_a(ma), .module_stop_b(mb),
    .module_stop_c(mc), .operating_power_mode(opm), .software_reset(swr));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one cpu bus access held until waitrequest is sampled low; no other master writes
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= !rd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  // halt instruction pulse; transfer controller start stays clear
  task automatic halt();
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wake_wait();
    n = 0;
    while (wake_irq_start !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("wake pulse", wake_irq_start, 1'b1);
  endtask
  task automatic t_protect();
    bus(1'b1, 4'h1, 32'h0, 4'hf);
    chk("mstop a reset", rv, 32'hffff_ffff);
    bus(1'b1, 4'h3, 32'h0, 4'hf);
    chk("mstop c reset", rv, 32'hffff_0000);
    bus(1'b0, 4'h1, 32'h0, 4'hf);
    chk("mstop a locked", ma, 32'hffff_ffff);
    bus(1'b0, 4'h7, 32'h0000_5a02, 4'h3);
    bus(1'b0, 4'h1, 32'h0, 4'hf);
    chk("wrong key", ma, 32'hffff_ffff);
    bus(1'b0, 4'h7, 32'h0000_a502, 4'h3);
    bus(1'b0, 4'h1, 32'h0, 4'hf);
    chk("mstop a open", ma, 32'h0);
    bus(1'b0, 4'h1, 32'h1000_0000, 4'hf); // interrupts and transfer start clear first
    chk("transfer stop", ma, 32'h1000_0000);
    bus(1'b0, 4'h2, 32'h0000_0f0f, 4'hf);
    chk("mstop b", mb, 32'h0000_0f0f);
    bus(1'b0, 4'h3, 32'h0000_0001, 4'hf);
    chk("mstop c", mc, 32'h0000_0001);
    bus(1'b0, 4'h4, 32'h0000_0005, 4'hf);
    chk("power mode", opm, 3'h5);
    bus(1'b0, 4'h6, 32'h0000_a501, 4'hf);
    chk("soft reset", swr, 1'b1);
    bus(1'b0, 4'h5, 32'h2, 4'hf);
    bus(1'b0, 4'h0, 32'h0000_8000, 4'hf);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    chk("select readback", rv[15], 1'b1);
  endtask
  task automatic t_pending();
    write_pending <= 1'b1;
    halt();
    chk("halt while pending", in_standby, 1'b0);
    write_pending <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_first();
    halt();
    chk("standby", in_standby, 1'b1);
    chk("ie flag", ief, 1'b1);
    chk("cpu clock", cpu_clock_en, 1'b0);
    chk("periph clock", periph_clock_en, 1'b0);
    chk("osc off", osc_enable, 3'h0);
    chk("wdt stop", wdt_en, 1'b0);
    wk.raise(11);
    repeat (10) @(posedge clk_sys);
    chk("wdt reset ignored", in_standby, 1'b1);
    wk.drop();
    @(posedge clk_sys);
    wk.raise(3);
    wake_wait();
    chk("wait length", n >= 320, 1'b1);
    chk("osc back", osc_enable, 3'h1);
    wk.drop();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic t_sources();
    wd_opt <= 1'b0;
    bus(1'b0, 4'h5, 32'h0, 4'hf);
    for (int k = 0; k < 9; k++)
    begin
      halt();
      chk("wdt runs", wdt_en, 1'b1);
      wk.raise(k);
      wake_wait();
      wk.drop();
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task automatic t_pin();
    halt();
    wk.raise(9);
    repeat (40) @(posedge clk_sys);
    chk("reset held", reset_hold, 1'b1);
    chk("clock on", cpu_clock_en, 1'b1);
    wk.drop();
    repeat (10) @(posedge clk_sys);
    chk("reset freed", reset_hold, 1'b0);
  endtask
  task automatic t_por(input int k);
    halt();
    wk.raise(k);
    repeat (10) @(posedge clk_sys);
    chk("supply reset", reset_hold, 1'b1);
    wk.drop();
    repeat (10) @(posedge clk_sys);
    chk("supply freed", reset_hold, 1'b0);
  endtask
  // register start mode: stop bit set halts the watchdog, clear keeps it
  task automatic t_regmode();
    wd_mode <= 1'b1;
    for (int s = 1; s >= 0; s--)
    begin
      bus(1'b0, 4'h8, s, 4'h1);
      halt();
      chk("wdt register mode", wdt_en, !s);
      wk.raise(0);
      wake_wait();
      wk.drop();
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_protect();
    t_pending();
    t_first();
    t_sources();
    t_pin();
    t_por(12);
    t_por(10);
    t_por(11);
    t_regmode();
    close_out();
  end
  // hang guard
  initial
  begin
    #500000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
